// ---- shared/mme_pkg.sv ----
package mme_pkg;

  // dma_mode_control fields
  localparam int unsigned SRC_IO_BIT      = 5;
  localparam int unsigned DST_IO_BIT      = 4;

  // first instruction word fields
  localparam int unsigned RSVD_HI         = 29;
  localparam int unsigned RSVD_LO         = 24;
  localparam int unsigned COUNT_W         = 24;
  localparam int unsigned ADDR_W          = 32;

  // own register window
  localparam int unsigned REG_IDX_W       = 6;
  localparam logic [5:0]  FIRST_BYTE_IDX  = 6'h08;

  // data buffer
  localparam int unsigned FIFO_W          = 8;
  localparam int unsigned FIFO_D          = 32;
  localparam logic [23:0] BURST_BYTES     = 24'h000020;

  // reset values
  localparam logic [31:0] ADDR_RST        = 32'h0000_0000;
  localparam logic [23:0] COUNT_RST       = 24'h00_0000;

  typedef enum logic [2:0] {
    MME_IDLE,
    MME_RD_REQ,
    MME_RD_REG,
    MME_WR_REQ,
    MME_RESTORE,
    MME_DONE
  } mme_state_t;

endpackage

// ---- core/mme_ram.sv ----
`timescale 1ns/1ps
module mme_ram #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 32,
  parameter int unsigned AW    = 5
) (
  input  wire logic             clk,
  input  wire logic             wr_en,
  input  wire logic [AW-1:0]    wr_addr,
  input  wire logic [WIDTH-1:0] wr_data,
  input  wire logic             rd_en,
  input  wire logic [AW-1:0]    rd_addr,
  output logic      [WIDTH-1:0] rd_data_r
);

  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rd_en) begin
      rd_data_r <= mem[rd_addr];
    end
  end

endmodule

// ---- core/mme_fifo.sv ----
`timescale 1ns/1ps
module mme_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 32
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int unsigned AW = $clog2(DEPTH);

  logic [AW:0]   wr_ptr_r;
  logic [AW:0]   rd_ptr_r;
  logic          out_valid_r;
  wire  [AW:0]   mem_cnt  = wr_ptr_r - rd_ptr_r;
  wire           mem_full = (mem_cnt == (AW+1)'(DEPTH));
  wire           mem_empt = (mem_cnt == '0);
  wire           push     = in_valid && !mem_full;
  // refill the output stage when it is empty or being drained
  wire           fetch    = !mem_empt && (!out_valid_r || out_ready);

  assign in_ready  = !mem_full;
  assign out_valid = out_valid_r;

  always_ff @(posedge clk) begin
    if (reset) begin
      wr_ptr_r    <= '0;
      rd_ptr_r    <= '0;
      out_valid_r <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (fetch) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
      if (fetch) begin
        out_valid_r <= 1'b1;
      end else if (out_ready) begin
        out_valid_r <= 1'b0;
      end
    end
  end

  mme_ram #(
    .WIDTH (WIDTH),
    .DEPTH (DEPTH),
    .AW    (AW)
  ) u_ram (
    .clk       (clk),
    .wr_en     (push),
    .wr_addr   (wr_ptr_r[AW-1:0]),
    .wr_data   (in_data),
    .rd_en     (fetch),
    .rd_addr   (rd_ptr_r[AW-1:0]),
    .rd_data_r (out_data)
  );

endmodule

// ---- core/mme_engine.sv ----
// Function
// - mode bits 5 and 4 pick io or memory space for source, destination
// - copy exactly the programmed byte count from source to destination
// - any count up to the full 24-bit range is one move
// - source and destination low two address bits differ: illegal interrupt
// - read a burst into the buffer, then write it out, burst by burst
// - count down as bytes move; at zero finish and fetch next instruction
// - pointer save holds source; data structure address restored after each nonzero-count move
// - any set bit among 29 to 24 of word one: illegal interrupt
// - byte count is bits 23 to 0 of word one
// - word two is source in pointer save, word three destination in temp
// - on own chip select, register at low six address bits is used
// - first received byte register is never written by a move
// - register window moves get the same alignment check
`timescale 1ns/1ps
module mme_engine
  import mme_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset,
  // instruction from the sequencer
  input  wire logic        start,
  input  wire logic [31:0] instr_word0,
  input  wire logic [31:0] instr_word1,
  input  wire logic [31:0] instr_word2,
  input  wire logic [7:0]  dma_mode_control,
  output logic             busy,
  output logic             fetch_next,
  output logic             illegal_instr,
  output logic [31:0]      script_pointer_save,
  output logic [31:0]      temp_addr,
  output logic [23:0]      bytes_left,
  // data structure address holding register
  input  wire logic [31:0] data_structure_address,
  output logic [31:0]      dsa_wdata,
  output logic             dsa_we,
  // system bus master
  output logic             bus_req,
  output logic             bus_we,
  output logic             bus_io,
  output logic [31:0]      bus_addr,
  output logic [3:0]       bus_be,
  output logic [31:0]      bus_wdata,
  input  wire logic        bus_ack,
  input  wire logic [31:0] bus_rdata,
  // own register window
  input  wire logic        chip_sel_n,
  output logic             reg_rd,
  output logic             reg_wr,
  output logic [5:0]       reg_idx,
  output logic [7:0]       reg_wdata,
  input  wire logic [7:0]  reg_rdata
);

  mme_state_t  state_r;
  mme_state_t  state_nxt;
  logic [31:0] src_r;
  logic [31:0] dst_r;
  logic [23:0] count_r;
  logic [23:0] rd_left_r;
  logic [23:0] wr_left_r;
  logic [31:0] dsa_save_r;
  logic        src_io_r;
  logic        dst_io_r;
  logic        fetch_next_r;
  logic        illegal_r;
  logic        dsa_we_r;
  logic [31:0] dsa_wdata_r;

  // buffer handshake
  logic        fifo_in_valid;
  logic        fifo_in_ready;
  logic [7:0]  fifo_in_data;
  logic        fifo_out_valid;
  logic        fifo_out_ready;
  logic [7:0]  fifo_out_data;

  // start-time checks
  wire [23:0] start_count = instr_word0[COUNT_W-1:0];
  wire        rsvd_set    = |instr_word0[RSVD_HI:RSVD_LO];
  // same test whether or not the address hits the register window
  wire        misaligned  = instr_word1[1:0] != instr_word2[1:0];
  wire        bad_instr   = rsvd_set || misaligned;
  wire        zero_count  = start_count == COUNT_RST;
  wire        accept      = start && (state_r == MME_IDLE);

  // next burst: what remains after this byte, capped at the buffer depth
  wire [23:0] after_byte  = count_r - 24'h00_0001;
  wire [23:0] next_burst  = (after_byte > BURST_BYTES) ?
                            BURST_BYTES : after_byte;
  wire [23:0] first_burst = (start_count > BURST_BYTES) ?
                            BURST_BYTES : start_count;

  // access decode
  wire        reg_hit     = !chip_sel_n;
  wire        in_rd_req   = state_r == MME_RD_REQ;
  wire        in_wr_req   = state_r == MME_WR_REQ;
  wire        rd_can_go   = in_rd_req && (rd_left_r != COUNT_RST) &&
                            fifo_in_ready;
  wire        wr_can_go   = in_wr_req && fifo_out_valid;
  wire [31:0] cur_addr    = in_wr_req ? dst_r : src_r;
  wire [1:0]  lane        = cur_addr[1:0];
  wire        bus_rd_go   = rd_can_go && !reg_hit;
  wire        bus_wr_go   = wr_can_go && !reg_hit;
  wire        reg_rd_go   = rd_can_go && reg_hit;
  wire        reg_wr_hit  = wr_can_go && reg_hit;
  wire        reg_is_fbr  = cur_addr[REG_IDX_W-1:0] == FIRST_BYTE_IDX;
  wire        rd_byte_ok  = bus_rd_go && bus_ack;
  wire        wr_byte_ok  = (bus_wr_go && bus_ack) || reg_wr_hit;
  wire [7:0]  bus_byte    = bus_rdata[{lane, 3'b000} +: 8];
  wire        burst_rd_end = in_rd_req && (rd_left_r == COUNT_RST);
  wire        last_byte   = wr_byte_ok && (count_r == 24'h00_0001);
  wire        burst_wr_end = wr_byte_ok && (wr_left_r == 24'h00_0001);

  // bus side outputs
  assign bus_req   = bus_rd_go || bus_wr_go;
  assign bus_we    = in_wr_req;
  assign bus_io    = in_wr_req ? dst_io_r : src_io_r;
  assign bus_addr  = cur_addr;
  assign bus_be    = 4'h1 << lane;
  assign bus_wdata = {4{fifo_out_data}};

  // register window outputs; first-received-byte writes are dropped
  assign reg_rd    = reg_rd_go;
  assign reg_wr    = reg_wr_hit && !reg_is_fbr;
  assign reg_idx   = cur_addr[REG_IDX_W-1:0];
  assign reg_wdata = fifo_out_data;

  // buffer feed: bus data on ack, register data one cycle after strobe
  assign fifo_in_valid  = rd_byte_ok || (state_r == MME_RD_REG);
  assign fifo_in_data   = (state_r == MME_RD_REG) ? reg_rdata : bus_byte;
  assign fifo_out_ready = wr_byte_ok;

  assign busy                = state_r != MME_IDLE;
  assign fetch_next          = fetch_next_r;
  assign illegal_instr       = illegal_r;
  assign script_pointer_save = src_r;
  assign temp_addr           = dst_r;
  assign bytes_left          = count_r;
  assign dsa_we              = dsa_we_r;
  assign dsa_wdata           = dsa_wdata_r;

  mme_fifo #(
    .WIDTH (FIFO_W),
    .DEPTH (FIFO_D)
  ) u_fifo (
    .clk       (clk),
    .reset     (reset),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (fifo_in_data),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data)
  );

  // sequencing
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      MME_IDLE: begin
        if (accept && !bad_instr && zero_count) begin
          state_nxt = MME_DONE;
        end else if (accept && !bad_instr) begin
          state_nxt = MME_RD_REQ;
        end
      end
      MME_RD_REQ: begin
        if (reg_rd_go) begin
          state_nxt = MME_RD_REG;
        end else if (burst_rd_end) begin
          state_nxt = MME_WR_REQ;
        end
      end
      MME_RD_REG: begin
        state_nxt = MME_RD_REQ;
      end
      MME_WR_REQ: begin
        if (last_byte) begin
          state_nxt = MME_RESTORE;
        end else if (burst_wr_end) begin
          state_nxt = MME_RD_REQ;
        end
      end
      MME_RESTORE: begin
        state_nxt = MME_DONE;
      end
      MME_DONE: begin
        state_nxt = MME_IDLE;
      end
      default: begin
        state_nxt = MME_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_r <= MME_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // addresses: loaded from words two and three, stepped per byte
  always_ff @(posedge clk) begin
    if (reset) begin
      src_r    <= ADDR_RST;
      dst_r    <= ADDR_RST;
      src_io_r <= 1'b0;
      dst_io_r <= 1'b0;
    end else if (accept) begin
      src_r    <= instr_word1;
      dst_r    <= instr_word2;
      src_io_r <= dma_mode_control[SRC_IO_BIT];
      dst_io_r <= dma_mode_control[DST_IO_BIT];
    end else begin
      if (rd_byte_ok || reg_rd_go) begin
        src_r <= src_r + 32'h0000_0001;
      end
      if (wr_byte_ok) begin
        dst_r <= dst_r + 32'h0000_0001;
      end
    end
  end

  // total count falls only as bytes reach the destination
  always_ff @(posedge clk) begin
    if (reset) begin
      count_r <= COUNT_RST;
    end else if (accept) begin
      count_r <= start_count;
    end else if (wr_byte_ok) begin
      count_r <= count_r - 24'h00_0001;
    end
  end

  // per-burst read and write budgets
  always_ff @(posedge clk) begin
    if (reset) begin
      rd_left_r <= COUNT_RST;
      wr_left_r <= COUNT_RST;
    end else if (accept) begin
      rd_left_r <= first_burst;
      wr_left_r <= first_burst;
    end else if (burst_wr_end && !last_byte) begin
      // read and write budgets must match or the write phase starves
      rd_left_r <= next_burst;
      wr_left_r <= next_burst;
    end else begin
      if (rd_byte_ok || reg_rd_go) begin
        rd_left_r <= rd_left_r - 24'h00_0001;
      end
      if (wr_byte_ok) begin
        wr_left_r <= wr_left_r - 24'h00_0001;
      end
    end
  end

  // data structure address: saved at start, then written back with its old value the cycle after MME_RESTORE
  always_ff @(posedge clk) begin
    if (reset) begin
      dsa_save_r  <= ADDR_RST;
      dsa_wdata_r <= ADDR_RST;
      dsa_we_r    <= 1'b0;
    end else begin
      dsa_we_r <= 1'b0;
      if (accept) begin
        dsa_save_r <= data_structure_address;
      end
      if (state_r == MME_RESTORE) begin
        dsa_wdata_r <= dsa_save_r;
        dsa_we_r    <= 1'b1;
      end
    end
  end

  // completion and error pulses
  always_ff @(posedge clk) begin
    if (reset) begin
      fetch_next_r <= 1'b0;
      illegal_r    <= 1'b0;
    end else begin
      fetch_next_r <= state_r == MME_DONE;
      illegal_r    <= accept && bad_instr;
    end
  end

endmodule

// ---- bench/mme_engine_sva.sv ----
`timescale 1ns/1ps
module mme_engine_sva
  import mme_pkg::*;
(
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        start,
  input wire logic [31:0] instr_word0,
  input wire logic [31:0] instr_word1,
  input wire logic [31:0] instr_word2,
  input wire logic [7:0]  dma_mode_control,
  input wire logic        busy,
  input wire logic        fetch_next,
  input wire logic        illegal_instr,
  input wire logic [31:0] script_pointer_save,
  input wire logic [31:0] temp_addr,
  input wire logic [23:0] bytes_left,
  input wire logic [31:0] data_structure_address,
  input wire logic [31:0] dsa_wdata,
  input wire logic        dsa_we,
  input wire logic        bus_req,
  input wire logic        bus_we,
  input wire logic        bus_io,
  input wire logic [31:0] bus_addr,
  input wire logic [3:0]  bus_be,
  input wire logic        bus_ack,
  input wire logic        chip_sel_n,
  input wire logic        reg_rd,
  input wire logic        reg_wr,
  input wire logic [5:0]  reg_idx
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  logic [7:0]  mode_r;
  logic [31:0] dsa_r;
  logic [6:0]  pend_r;
  wire take = start && !busy;
  wire rsvd = |instr_word0[29:24];
  wire rd = (bus_req && !bus_we && bus_ack) || reg_rd;
  wire wr = (bus_req && bus_we && bus_ack) || reg_wr;
  always_ff @(posedge clk) begin
    if (take) begin
      mode_r <= dma_mode_control;
      dsa_r <= data_structure_address;
    end
  end
  // bytes buffered but not yet written out
  always_ff @(posedge clk) begin
    if (reset || take)
      pend_r <= 7'h0;
    else
      pend_r <= pend_r + 7'(rd) - 7'(wr);
  end
  sequence s_legal;
    take && !rsvd && instr_word1[1:0] == instr_word2[1:0];
  endsequence
  sequence s_zero;
    s_legal ##0 instr_word0[23:0] == 24'h0;
  endsequence
  rsvd_bits_a: assert property (take && rsvd |=> illegal_instr)
    else $error("reserved bits set but no illegal pulse");
  align_a: assert property (take && !rsvd &&
    instr_word1[1:0] != instr_word2[1:0] |=> illegal_instr)
    else $error("misaligned move but no illegal pulse");
  zero_move_a: assert property (s_zero |=> (busy && !bus_req)
    ##1 (fetch_next && !busy))
    else $error("zero count move misbehaved");
  load_regs_a: assert property (s_legal |=>
    bytes_left == $past(instr_word0[23:0]) &&
    script_pointer_save == $past(instr_word1) &&
    temp_addr == $past(instr_word2))
    else $error("count or addresses not loaded");
  space_sel_a: assert property (bus_req |-> bus_io ==
    (bus_we ? mode_r[DST_IO_BIT] : mode_r[SRC_IO_BIT]))
    else $error("wrong address space");
  count_dec_a: assert property (bus_req && bus_we && bus_ack |=>
    bytes_left == $past(bytes_left) - 24'h1)
    else $error("count not decremented");
  done_zero_a: assert property (fetch_next |-> bytes_left == 24'h0)
    else $error("fetch with bytes left");
  burst_order_a: assert property (bus_req |->
    (bus_we ? pend_r != 7'h0 : pend_r < 7'h20))
    else $error("write before buffered data or burst too long");
  first_byte_a: assert property (reg_wr |-> reg_idx != FIRST_BYTE_IDX)
    else $error("first byte register written");
  reg_window_a: assert property (reg_rd || reg_wr |->
    reg_idx == bus_addr[5:0] && !chip_sel_n && !bus_req)
    else $error("register window access wrong");
  dsa_keep_a: assert property (dsa_we |-> dsa_wdata == dsa_r)
    else $error("data structure address not restored");
  lane_sel_a: assert property (bus_req |->
    bus_be == (4'h1 << bus_addr[1:0]))
    else $error("byte enable does not match address lane");
endmodule

// ---- bench/mme_mem_model.sv ----
`timescale 1ns/1ps
module mme_mem_model #(
  parameter logic [25:0] WIN = 26'h3ff_ffff
) (
  input  wire logic        clk,
  input  wire logic        bus_req,
  input  wire logic        bus_we,
  input  wire logic [31:0] bus_addr,
  input  wire logic [31:0] bus_wdata,
  output logic             bus_ack,
  output logic [31:0]      bus_rdata,
  output logic             chip_sel_n,
  input  wire logic        reg_rd,
  input  wire logic        reg_wr,
  input  wire logic [5:0]  reg_idx,
  input  wire logic [7:0]  reg_wdata,
  output logic [7:0]       reg_rdata
);
  logic [7:0]  mem [logic [31:0]];
  logic [7:0]  regs [64];
  logic [1:0]  wait_r = 2'h0;
  logic [31:0] junk_r = 32'h0;
  function automatic logic [7:0] seed_byte(input logic [31:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5a;
  endfunction
  function automatic logic [7:0] rd(input logic [31:0] a);
    return mem.exists(a) ? mem[a] : seed_byte(a);
  endfunction
  initial begin
    foreach (regs[i]) regs[i] = 8'(i) ^ 8'ha5;
  end
  assign chip_sel_n = bus_addr[31:6] != WIN;
  assign bus_ack = bus_req && chip_sel_n && wait_r == 2'h0;
  // only the addressed lane carries data
  always_comb begin
    bus_rdata = junk_r;
    if (bus_ack && !bus_we) bus_rdata[8*bus_addr[1:0] +: 8] = rd(bus_addr);
  end
  always @(posedge clk) begin
    junk_r <= $urandom;
    if (bus_ack && bus_we) mem[bus_addr] = bus_wdata[8*bus_addr[1:0] +: 8];
    if (bus_ack) wait_r <= 2'($urandom_range(2));
    else if (bus_req && wait_r != 2'h0) wait_r <= wait_r - 2'h1;
    reg_rdata <= reg_rd ? regs[reg_idx] : ~reg_rdata;
    if (reg_wr) regs[reg_idx] = reg_wdata;
  end
endmodule

// ---- bench/mme_engine_bench.sv ----
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin fails++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (a), (b)); end end
module mme_engine_bench;
  import mme_pkg::*;
  localparam logic [31:0] WBASE = 32'hffff_ffc0;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic        start = 1'b0;
  logic [31:0] instr_word0 = 32'h0, instr_word1 = 32'h0, instr_word2 = 32'h0;
  logic [7:0]  dma_mode_control = 8'h00;
  logic [31:0] data_structure_address = 32'h1234_5678;
  logic        busy, fetch_next, illegal_instr, dsa_we, bus_req, bus_we;
  logic        bus_io, bus_ack, chip_sel_n, reg_rd, reg_wr;
  logic [31:0] script_pointer_save, temp_addr, dsa_wdata, bus_addr;
  logic [31:0] bus_wdata, bus_rdata;
  logic [23:0] bytes_left;
  logic [3:0]  bus_be;
  logic [5:0]  reg_idx;
  logic [7:0]  reg_wdata, reg_rdata;
  int          fails = 0;
  int          n_checks = 0;
  mme_engine mme_engine_inst (.*);
  mme_mem_model mme_mem_model_inst (.*);
  always #5 clk = ~clk;
  task automatic go(input logic [31:0] w0, w1, w2, input logic [7:0] m);
    @(negedge clk);
    instr_word0 = w0;
    instr_word1 = w1;
    instr_word2 = w2;
    dma_mode_control = m;
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
  endtask
  task automatic bad(input logic [31:0] w0, w1, w2);
    go(w0, w1, w2, 8'h30);
    `CHK(illegal_instr, 1'b1)
    @(negedge clk);
    `CHK({busy, bus_req, dsa_we}, 3'b000)
  endtask
  task automatic copy(input logic [31:0] s, d, input logic [23:0] n,
                      input logic [7:0] m);
    logic [31:0] dv;
    logic        fn;
    go({8'h00, n}, s, d, m);
    `CHK(bytes_left, n)
    `CHK({script_pointer_save, temp_addr}, {s, d})
    dv = 32'hx;
    fn = 1'b0;
    for (int i = 0; i < 3000 && busy !== 1'b0; i++) begin
      @(negedge clk);
      if (dsa_we === 1'b1) dv = dsa_wdata;
      if (fetch_next === 1'b1) fn = 1'b1;
    end
    `CHK({busy, fn, bytes_left}, {2'b01, 24'h0})
    `CHK(dv, data_structure_address)
  endtask
  task automatic cmp_mem(input logic [31:0] s, d, input logic [23:0] n);
    logic [7:0] e;
    for (int i = 0; i < n; i++) begin
      e = mme_mem_model_inst.seed_byte(s + i);
      `CHK(mme_mem_model_inst.mem[d + i], e)
    end
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #300_000;
    fails++;
    end_sim();
  end
  initial begin
    logic [31:0] s;
    logic [31:0] d;
    logic [23:0] n;
    logic [7:0]  e;
    void'($urandom(32'h00d3f477));
    repeat (8) @(negedge clk);
    reset = 1'b0;
    `CHK({busy, bytes_left, temp_addr}, {1'b0, COUNT_RST, ADDR_RST})
    go(32'h0, 32'h10, 32'h1000_0010, 8'h00);
    `CHK(busy, 1'b1)
    @(negedge clk);
    `CHK({fetch_next, busy, bus_req}, 3'b100)
    for (int b = 24; b < 30; b++) bad(32'h1 << b, 32'h0, 32'h1000_0000);
    bad(32'h4, 32'h1, 32'h1000_0002);
    bad(32'h4, 32'h201, WBASE + 32'h8);
    for (int i = 0; i < 16; i++) begin
      n = i == 0 ? 24'h1 : i == 1 ? 24'h20 : i == 2 ? 24'h21 :
          24'($urandom_range(70, 1));
      s = {16'h0, 16'($urandom)};
      d = 32'h1000_0000 + 32'(i << 8) + {30'h0, s[1:0]};
      copy(s, d, n, 8'(i % 4) << 4);
      cmp_mem(s, d, n);
    end
    e = mme_mem_model_inst.regs[8];
    copy(32'h200, WBASE + 32'h8, 24'h4, 8'h00);
    `CHK(mme_mem_model_inst.regs[8], e)
    for (int j = 1; j < 4; j++) begin
      e = mme_mem_model_inst.seed_byte(32'h200 + j);
      `CHK(mme_mem_model_inst.regs[8 + j], e)
    end
    copy(WBASE + 32'h10, 32'h1000_f000, 24'h4, 8'h00);
    for (int j = 0; j < 4; j++) begin
      e = mme_mem_model_inst.regs[16 + j];
      `CHK(mme_mem_model_inst.mem[32'h1000_f000 + j], e)
    end
    go({8'h00, 24'hff_ffff}, 32'h300, 32'h1000_e000, 8'h00);
    `CHK(bytes_left, 24'hff_ffff)
    repeat (40) @(negedge clk);
    `CHK(busy, 1'b1)
    reset = 1'b1;
    repeat (2) @(negedge clk);
    reset = 1'b0;
    `CHK({busy, bus_req, bytes_left}, {2'b00, COUNT_RST})
    end_sim();
  end
endmodule
bind mme_engine mme_engine_sva mme_engine_sva_inst (.*);
